// ==== hw/stc_pkg.sv ====
// Constants for the sixteen-bit timer/counter.
// Assumes a single core clock of 100 MHz; all control bits arrive as plain ports.
// Operation
// - Count is 16 bits, high and low byte, each readable and writable.
// - Count increments from 0000h to FFFFh, then wraps to zero.
// - Each rollover sets and holds the overflow flag.
// - Interrupt request is the flag gated by the overflow interrupt enable.
// - Three modes: timer, synchronous counter, asynchronous counter; clock_source_select picks counter, sync_bypass picks asynchronous.
// - Timer mode advances once per instruction cycle.
// - Counter mode advances on each rising edge of the external input.
// - Count only while timer_on is set; otherwise hold.
// - Special event trigger from capture/compare unit clears the count.
// - With osc_enable set, oscillator pins are inputs and read as zero.
// - Two-bit prescale_select divides by 1, 2, 4 or 8.
// - After enabling counter mode, a falling edge must precede the first count.
// - Synchronous counting uses the synchronizer's agreement filter; asynchronous counting skips the filter.
// - Timer mode counts oscillator_frequency/4; sync_bypass has no effect.
package stc_pkg;
    localparam int          STC_CNT_W       = 16;
    localparam int          STC_BYTE_W      = 8;
    localparam int          STC_PS_W        = 2;
    localparam int          STC_INSTR_DIV   = 4;
    localparam int          STC_INSTR_DIV_W = 2;
    localparam logic [15:0] STC_CNT_RESET   = 16'h0000;
    localparam logic [15:0] STC_CNT_MAX     = 16'hFFFF;
    localparam logic [7:0]  STC_BYTE_ZERO   = 8'h00;
    localparam logic [1:0]  STC_PS_DIV1     = 2'h0;
    localparam logic [1:0]  STC_PS_DIV2     = 2'h1;
    localparam logic [1:0]  STC_PS_DIV4     = 2'h2;
    localparam logic [1:0]  STC_PS_DIV8     = 2'h3;
    localparam int          STC_PIN_OSC_OUT = 6;
    localparam int          STC_PIN_OSC_IN  = 7;
endpackage

// ==== hw/stc_prescaler.sv ====
// Prescaler: divides a stream of count ticks by 1, 2, 4 or 8.
// Assumes ticks are single-cycle pulses on the core clock.
`timescale 1ns/1ps
module stc_prescaler
    import stc_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_b,
    // Control
    input  wire logic                clear,
    input  wire logic [STC_PS_W-1:0] prescale_select,
    // Ticks
    input  wire logic                tick_in,
    output logic                     tick_out
);
    import stc_pkg::*;

    logic [2:0] div_q;
    logic [2:0] div_d;
    logic [2:0] mask;

    assign mask = (prescale_select == STC_PS_DIV1) ? 3'h0 :
                  (prescale_select == STC_PS_DIV2) ? 3'h1 :
                  (prescale_select == STC_PS_DIV4) ? 3'h3 : 3'h7;
    // Terminal tick when all selected divider bits are set
    assign tick_out = tick_in && ((div_q & mask) == mask);
    assign div_d    = clear ? 3'h0 : (tick_in ? 3'(div_q + 3'h1) : div_q);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_d;
        end
    end
endmodule

// ==== hw/stc_timer.sv ====
// Sixteen-bit timer/counter top: count pair, prescaler, edge logic, overflow flag.
// Assumes a 100 MHz core clock; ext_clk and osc pins are asynchronous pins.
`timescale 1ns/1ps
module stc_timer
    import stc_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // Control bits
    input  wire logic                  timer_on,
    input  wire logic                  clock_source_select,
    input  wire logic                  sync_bypass,
    input  wire logic                  osc_enable,
    input  wire logic [STC_PS_W-1:0]   prescale_select,
    input  wire logic                  overflow_irq_enable,
    // Count register access
    input  wire logic                  low_wr,
    input  wire logic                  high_wr,
    input  wire logic [STC_BYTE_W-1:0] wr_data,
    output logic [STC_BYTE_W-1:0]      count_low_byte,
    output logic [STC_BYTE_W-1:0]      count_high_byte,
    // Overflow flag access
    input  wire logic                  flag_clear,
    output logic                       overflow_flag,
    output logic                       irq,
    // Special event trigger
    input  wire logic                  special_event,
    // External clock input
    input  wire logic                  ext_clk,
    // Oscillator pins, bits 7:6 of the port
    input  wire logic [1:0]            osc_pin_in,
    input  wire logic [1:0]            osc_dir_in,
    input  wire logic [1:0]            osc_out_latch,
    output logic [1:0]                 osc_pin_oe,
    output logic [1:0]                 osc_pin_out,
    output logic [1:0]                 osc_pin_read
);
    import stc_pkg::*;

    logic [STC_CNT_W-1:0]       cnt_q;
    logic [STC_CNT_W-1:0]       cnt_d;
    logic                       flag_q;
    logic [2:0]                 ext_sync_q;
    logic                       ext_level_q;
    logic                       armed_q;
    logic                       counter_mode_q;
    logic [STC_INSTR_DIV_W-1:0] phase_q;
    logic [1:0]                 pin_q;
    logic [1:0]                 pin_s1_q;
    logic [1:0]                 pin_s2_q;
    logic [1:0]                 pin_s3_q;
    logic [1:0]                 pin_lvl_q;
    logic [1:0]                 pin_lvl_d;
    logic [1:0]                 pin_agree;
    logic                       ext_rise_sync;
    logic                       ext_fall_sync;
    logic                       ext_rise_raw;
    logic                       ext_fall_raw;
    logic                       ext_rise;
    logic                       ext_fall;
    logic                       instr_tick;
    logic                       src_tick;
    logic                       step;
    logic                       wrap;
    logic [STC_CNT_W-1:0]       cnt_inc;

    // Three-stage synchronizer on the external clock; second and third stages agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_sync_q <= 3'h0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], ext_clk};
        end
    end

    // Filtered level: updates only when stages two and three agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_level_q <= 1'b0;
        end else if (ext_sync_q[1] == ext_sync_q[2]) begin
            ext_level_q <= ext_sync_q[2];
        end
    end

    assign ext_rise_sync = (ext_sync_q[1] == ext_sync_q[2]) && ext_sync_q[2] && !ext_level_q;
    assign ext_fall_sync = (ext_sync_q[1] == ext_sync_q[2]) && !ext_sync_q[2] && ext_level_q;
    // Asynchronous mode skips the agreement filter, so edges surface one stage earlier.
    // Everything still runs on clk, trading a little latency for a single clock domain.
    assign ext_rise_raw  = ext_sync_q[1] && !ext_sync_q[2];
    assign ext_fall_raw  = !ext_sync_q[1] && ext_sync_q[2];
    assign ext_rise      = sync_bypass ? ext_rise_raw : ext_rise_sync;
    assign ext_fall      = sync_bypass ? ext_fall_raw : ext_fall_sync;

    // Instruction-cycle tick, one in four core clocks
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= '0;
        end else begin
            phase_q <= STC_INSTR_DIV_W'(phase_q + 1'b1);
        end
    end
    assign instr_tick = (phase_q == STC_INSTR_DIV_W'(STC_INSTR_DIV - 1));

    // Counter mode arms only after a falling edge once enabled
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            armed_q        <= 1'b0;
            counter_mode_q <= 1'b0;
        end else begin
            counter_mode_q <= timer_on && clock_source_select;
            if (!(timer_on && clock_source_select)) begin
                armed_q <= 1'b0;
            end else if (ext_fall) begin
                armed_q <= 1'b1;
            end
        end
    end

    // Source choice
    assign src_tick = timer_on && (clock_source_select
                    ? (ext_rise && armed_q && counter_mode_q)
                    : instr_tick);

    stc_prescaler u_prescaler (
        .clk             (clk),
        .rst_b           (rst_b),
        .clear           (special_event || low_wr || high_wr),
        .prescale_select (prescale_select),
        .tick_in         (src_tick),
        .tick_out        (step)
    );

    // Full 16-bit increment carries low into high in one step
    assign cnt_inc = STC_CNT_W'(cnt_q + 16'h0001);
    assign wrap    = step && (cnt_q == STC_CNT_MAX) && !special_event && !low_wr && !high_wr;

    always_comb begin
        cnt_d = cnt_q;
        if (step) begin
            cnt_d = cnt_inc;
        end
        if (low_wr) begin
            cnt_d[STC_BYTE_W-1:0] = wr_data;
        end
        if (high_wr) begin
            cnt_d[STC_CNT_W-1:STC_BYTE_W] = wr_data;
        end
        if (special_event) begin
            cnt_d = STC_CNT_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= STC_CNT_RESET;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
        end else if (wrap) begin
            flag_q <= 1'b1;
        end else if (flag_clear) begin
            flag_q <= 1'b0;
        end
    end

    // Pins are asynchronous: three stages, a bit moves once stages two and three agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_q  <= 2'h0;
            pin_s2_q  <= 2'h0;
            pin_s3_q  <= 2'h0;
            pin_lvl_q <= 2'h0;
        end else begin
            pin_s1_q  <= osc_pin_in;
            pin_s2_q  <= pin_s1_q;
            pin_s3_q  <= pin_s2_q;
            pin_lvl_q <= pin_lvl_d;
        end
    end

    assign pin_agree = ~(pin_s2_q ^ pin_s3_q);
    assign pin_lvl_d = (pin_agree & pin_s3_q) | (~pin_agree & pin_lvl_q);

    // Port read value of the oscillator pins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_q <= 2'h0;
        end else begin
            pin_q <= osc_enable ? 2'h0 : pin_lvl_q;
        end
    end

    assign count_low_byte  = cnt_q[STC_BYTE_W-1:0];
    assign count_high_byte = cnt_q[STC_CNT_W-1:STC_BYTE_W];
    assign overflow_flag   = flag_q;
    assign irq             = flag_q && overflow_irq_enable;
    // Direction bit low means output; oscillator forces inputs
    assign osc_pin_oe      = osc_enable ? 2'h0 : ~osc_dir_in;
    assign osc_pin_out     = osc_out_latch;
    assign osc_pin_read    = pin_q;

    property p_wrap_zero;
        @(posedge clk) disable iff (!rst_b)
        wrap |=> (cnt_q == STC_CNT_RESET);
    endproperty
    a_wrap_zero: assert property (p_wrap_zero) else $error("count did not wrap to zero");

    property p_flag_set;
        @(posedge clk) disable iff (!rst_b)
        wrap |=> flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overflow flag not set");

    property p_flag_hold;
        @(posedge clk) disable iff (!rst_b)
        (flag_q && !flag_clear) |=> flag_q;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by itself");

    property p_irq_gate;
        @(posedge clk) disable iff (!rst_b)
        (wrap && overflow_irq_enable) |=> (irq || !overflow_irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq gating wrong");

    property p_hold_off;
        @(posedge clk) disable iff (!rst_b)
        (!timer_on && !low_wr && !high_wr && !special_event) |=> $stable(cnt_q);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("count moved while off");

    property p_special;
        @(posedge clk) disable iff (!rst_b)
        special_event |=> (cnt_q == STC_CNT_RESET);
    endproperty
    a_special: assert property (p_special) else $error("special event did not clear");

    property p_carry;
        @(posedge clk) disable iff (!rst_b)
        (step && cnt_q[7:0] == 8'hFF && !low_wr && !high_wr && !special_event)
        |=> (cnt_q[15:8] == $past(cnt_q[15:8]) + 8'h01);
    endproperty
    a_carry: assert property (p_carry) else $error("no carry into high byte");

    property p_timer_rate;
        @(posedge clk) disable iff (!rst_b)
        (step && !clock_source_select) |-> instr_tick;
    endproperty
    a_timer_rate: assert property (p_timer_rate) else $error("timer step off cycle");

    property p_osc_pins;
        @(posedge clk) disable iff (!rst_b)
        osc_enable |-> (osc_pin_oe == 2'h0) ##1 (osc_pin_read == 2'h0 || !$past(osc_enable));
    endproperty
    a_osc_pins: assert property (p_osc_pins) else $error("osc pins not forced");
endmodule

// ==== verification/stc_ext_src.sv ====
// External clock source model for the timer's count input.
// Assumes go is a one-cycle pulse; n level toggles, each after half clk cycles.
`timescale 1ns/1ps
module stc_ext_src (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Burst request
    input  wire logic       go,
    input  wire logic [7:0] n,
    input  wire logic [3:0] half,
    // Pin and status
    output logic            ext_clk,
    output logic            busy
);
    logic [7:0] left_q;
    logic [3:0] cnt_q;
    // Level stands still between bursts, as a gated source would
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_clk <= 1'b0;
            busy    <= 1'b0;
            left_q  <= 8'h00;
            cnt_q   <= 4'h0;
        end else if (!busy && go) begin
            busy   <= 1'b1;
            left_q <= n;
            cnt_q  <= half;
        end else if (busy && cnt_q == 4'h1) begin
            ext_clk <= ~ext_clk;
            left_q  <= left_q - 8'h01;
            cnt_q   <= half;
            busy    <= (left_q != 8'h01);
        end else if (busy) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the sixteen-bit timer/counter.
// Assumes stc_pkg and the external source model are compiled first.
`timescale 1ns/1ps
module tb;
    import stc_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        timer_on, clock_source_select, sync_bypass, osc_enable;
    logic        overflow_irq_enable, low_wr, high_wr, flag_clear, special_event;
    logic        overflow_flag, irq, ext_clk, busy, go;
    logic [1:0]  prescale_select, osc_pin_in, osc_dir_in, osc_out_latch, pin_ext;
    logic [1:0]  osc_pin_oe, osc_pin_out, osc_pin_read;
    logic [7:0]  wr_data, count_low_byte, count_high_byte, n;
    logic [3:0]  half;
    logic [15:0] v;
    logic [17:0] nt;
    logic [17:0] note_q[$];
    event        sample_ev;
    event        cmp_done_ev;
    int          num_errors = 0;
    int          checks = 0;
    int          seed = 32'h6e13;
    // Pin level: design drive where enabled, outside drive elsewhere
    assign osc_pin_in = (osc_pin_oe & osc_pin_out) | (~osc_pin_oe & pin_ext);
    always #5 clk = ~clk;
    stc_timer u_stc_timer (.clk, .rst_b, .timer_on, .clock_source_select, .sync_bypass,
        .osc_enable, .prescale_select, .overflow_irq_enable, .low_wr, .high_wr, .wr_data,
        .count_low_byte, .count_high_byte, .flag_clear, .overflow_flag, .irq,
        .special_event, .ext_clk, .osc_pin_in, .osc_dir_in, .osc_out_latch, .osc_pin_oe,
        .osc_pin_out, .osc_pin_read);
    stc_ext_src u_stc_ext_src (.clk, .rst_b, .go, .n, .half, .ext_clk, .busy);
    task automatic step(int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic note(logic [1:0] kind, logic [15:0] val);
        note_q.push_back({kind, val});
        -> sample_ev;
        // Wait for the watcher, so no later input change races the compare
        @(cmp_done_ev);
    endtask
    task automatic cmp_cnt(logic [15:0] e, logic [15:0] g);
        checks++;
        if (e !== g) begin
            num_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_bits(logic [3:0] e, logic [3:0] g);
        checks++;
        if (e !== g) begin
            num_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic wr(logic [15:0] val);
        high_wr = 1'b1;
        wr_data = val[15:8];
        step();
        high_wr = 1'b0;
        low_wr = 1'b1;
        wr_data = val[7:0];
        step();
        low_wr = 1'b0;
    endtask
    task automatic wait_change();
        logic [15:0] old;
        int i;
        old = {count_high_byte, count_low_byte};
        for (i = 0; i < 200 && {count_high_byte, count_low_byte} === old; i++) step();
    endtask
    // Sync latency is a few cycles, so a fixed margin follows each burst
    task automatic burst(logic [7:0] k);
        int i;
        n = k;
        half = 4'(3 + ($random(seed) & 3));
        go = 1'b1;
        step();
        go = 1'b0;
        for (i = 0; i < 500 && busy === 1'b1; i++) step();
        step(8);
    endtask
    task automatic final_report();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial forever begin
        @(sample_ev);
        while (note_q.size() > 0) begin
            nt = note_q.pop_front();
            case (nt[17:16])
                2'h0: cmp_cnt(nt[15:0], {count_high_byte, count_low_byte});
                2'h1: cmp_bits(nt[3:0], {2'h0, overflow_flag, irq});
                default: cmp_bits(nt[3:0], {osc_pin_oe, osc_pin_read});
            endcase
        end
        -> cmp_done_ev;
    end
    initial begin
        #(20000 * 10);
        num_errors++;
        final_report();
    end
    initial begin
        {timer_on, clock_source_select, sync_bypass, osc_enable, overflow_irq_enable} = '0;
        {low_wr, high_wr, flag_clear, special_event, go} = '0;
        {prescale_select, osc_dir_in, osc_out_latch, pin_ext} = '0;
        wr_data = 8'h00;
        n = 8'h00;
        half = 4'h3;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        step();
        note(2'h0, 16'h0000);
        note(2'h1, 16'h0000);
        v = 16'($random(seed));
        wr(v);
        note(2'h0, v);
        step(50);
        note(2'h0, v);
        $display("test reset_write_hold done");
        for (int ps = 0; ps < 4; ps++) begin
            prescale_select = 2'(ps);
            sync_bypass = 1'($random(seed));
            wr(16'h12FF);
            timer_on = 1'b1;
            wait_change();
            note(2'h0, 16'h1300);
            step((4 << ps) - 1);
            note(2'h0, 16'h1300);
            step();
            note(2'h0, 16'h1301);
            timer_on = 1'b0;
        end
        $display("test timer_rates done");
        overflow_irq_enable = 1'b1;
        wr(16'hFFFF);
        timer_on = 1'b1;
        wait_change();
        timer_on = 1'b0;
        note(2'h0, 16'h0000);
        note(2'h1, 16'h0003);
        overflow_irq_enable = 1'b0;
        step(6);
        note(2'h1, 16'h0002);
        flag_clear = 1'b1;
        step();
        flag_clear = 1'b0;
        step();
        note(2'h1, 16'h0000);
        wr(16'hA5C3);
        special_event = 1'b1;
        step();
        special_event = 1'b0;
        note(2'h0, 16'h0000);
        $display("test overflow_clear done");
        sync_bypass = 1'b0;
        prescale_select = 2'h0;
        clock_source_select = 1'b1;
        timer_on = 1'b1;
        burst(8'h01);
        note(2'h0, 16'h0000);
        burst(8'h06);
        note(2'h0, 16'h0003);
        timer_on = 1'b0;
        wr(16'h0000);
        sync_bypass = 1'b1;
        prescale_select = 2'h1;
        timer_on = 1'b1;
        burst(8'h08);
        note(2'h0, 16'h0002);
        timer_on = 1'b0;
        $display("test counter_modes done");
        osc_enable = 1'b1;
        osc_out_latch = 2'($random(seed));
        pin_ext = ~osc_out_latch;
        step(2);
        note(2'h2, 16'h0000);
        osc_enable = 1'b0;
        // Pin reads pass the three-stage filter and then the read register
        step(5);
        note(2'h2, {14'h3, osc_out_latch});
        osc_dir_in = 2'h3;
        step(5);
        note(2'h2, {14'h0, pin_ext});
        $display("test osc_pins done");
        step(2);
        final_report();
    end
endmodule
